/* rtl/uiw_defines.svh */
// Timing and width constants of the UART interrupt and wake-up logic
`ifndef UIW_DEFINES_SVH
`define UIW_DEFINES_SVH

`define UIW_CLK_HZ          20000000
`define UIW_STARTUP_NS      1000
`define UIW_STARTUP_CYCLES  (((`UIW_STARTUP_NS) * ((`UIW_CLK_HZ) / 1000000) + 999) / 1000)
`define UIW_CNT_W           16
`define UIW_WORD_W          9
`define UIW_BIT8_POS        7
`define UIW_BIT9_POS        8

`endif

/* rtl/uiw_pkg.sv */
// Types of the UART interrupt and wake-up logic
package uiw_pkg;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_LOW,
        PWR_STARTUP
    } uiw_pwr_t;
endpackage : uiw_pkg

/* rtl/uiw_irq_wake.sv */
// UART interrupt merge, address detect qualifier and RX wake-up logic
`include "uiw_defines.svh"

module uiw_irq_wake #(
    parameter int STARTUP_CYCLES = `UIW_STARTUP_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Status flags from the UART core
    input  wire logic       txRegEmptyFlag,
    input  wire logic       txIdleFlag,
    input  wire logic       rx_data_avail_flag,
    input  wire logic       rxOverrunFlag,
    input  wire logic [8:0] rxWord,
    // Control bits of the second control register
    input  wire logic       txEmptyIrqEnable,
    input  wire logic       txIdleIrqEnable,
    input  wire logic       rx_irq_enable,
    input  wire logic       addr_detect_enable,
    input  wire logic       wakeEnable,
    input  wire logic       word_length_select,
    // Other enables
    input  wire logic       serial_unit_enable,
    input  wire logic       receiver_enable,
    input  wire logic       global_irq_enable,
    input  wire logic       serial_irq_mask,
    input  wire logic       stackFull,
    // Power state and pins
    input  wire logic       lowPowerRequest,
    input  wire logic       rxPin,
    // Outputs
    output logic            irqReqN,
    output logic            uartClkEnable,
    output logic            wakeUp,
    output logic            rxDiscard,
    output logic            addrWord
);
    // ============================================================
    // Parameter check
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << `UIW_CNT_W)) begin : gBadStartup
        $error("STARTUP_CYCLES out of range");
    end

    // ============================================================
    // Reset synchroniser
    logic rstMeta;
    logic rstSync;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ============================================================
    // State
    typedef struct packed {
        uiw_pkg::uiw_pwr_t     pwr;
        logic [`UIW_CNT_W-1:0] cnt;
        logic                  wakeArmed;
        logic                  wakeIrqPend;
        logic                  rxPrev;
        logic                  txEmptyPrev;
        logic                  txIdlePrev;
        logic                  rxAvailPrev;
        logic                  ovrPrev;
        logic                  irqN;
        logic                  wake;
        logic                  addr;
    } uiw_state_t;

    uiw_state_t st;
    uiw_state_t next_st;

    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction : rise

    // ============================================================
    // Decoding helpers
    function automatic logic pickHighBit(input logic [8:0] word, input logic nineBits);
        return nineBits ? word[`UIW_BIT9_POS] : word[`UIW_BIT8_POS];
    endfunction : pickHighBit

    function automatic logic passGates(
        input logic req,
        input logic mask,
        input logic glob,
        input logic full
    );
        return req & mask & glob & ~full;
    endfunction : passGates

    // ============================================================
    // Next state
    logic highBit;
    logic rxQual;
    logic eventAny;
    logic wakeFall;
    logic armOk;
    logic txEmptyEvt;
    logic txIdleEvt;
    logic rxAvailEvt;
    logic ovrEvt;
    logic gatesOpen;

    always_comb begin
        next_st    = st;
        highBit    = pickHighBit(rxWord, word_length_select);
        rxQual     = ~addr_detect_enable | highBit;
        armOk      = wakeEnable & serial_unit_enable & receiver_enable & rx_irq_enable;
        wakeFall   = st.rxPrev & ~rxPin;
        txEmptyEvt = rise(txRegEmptyFlag, st.txEmptyPrev);
        txIdleEvt  = rise(txIdleFlag, st.txIdlePrev);
        rxAvailEvt = rise(rx_data_avail_flag, st.rxAvailPrev);
        ovrEvt     = rise(rxOverrunFlag, st.ovrPrev);
        gatesOpen  = passGates(1'b1, serial_irq_mask, global_irq_enable, stackFull);
        eventAny   = 1'b0;
        next_st.wake   = 1'b0;
        next_st.addr   = 1'b0;
        next_st.rxPrev = rxPin;
        // Flags are only sampled, never written back
        next_st.txEmptyPrev = txRegEmptyFlag;
        next_st.txIdlePrev  = txIdleFlag;
        next_st.rxAvailPrev = rx_data_avail_flag;
        next_st.ovrPrev     = rxOverrunFlag;
        unique case (st.pwr)
            uiw_pkg::PWR_RUN: begin
                if (txEmptyEvt && txEmptyIrqEnable) begin
                    eventAny = 1'b1;
                end
                if (txIdleEvt && txIdleIrqEnable) begin
                    eventAny = 1'b1;
                end
                if (rxAvailEvt && rx_irq_enable && rxQual) begin
                    eventAny = 1'b1;
                end
                if (ovrEvt && rx_irq_enable) begin
                    eventAny = 1'b1;
                end
                if (rxAvailEvt && addr_detect_enable && highBit) begin
                    next_st.addr = 1'b1;
                    eventAny     = 1'b1;
                end
                if (st.wakeIrqPend) begin
                    eventAny            = 1'b1;
                    next_st.wakeIrqPend = 1'b0;
                end
                if (lowPowerRequest) begin
                    next_st.pwr       = uiw_pkg::PWR_LOW;
                    next_st.wakeArmed = armOk;
                end
            end
            uiw_pkg::PWR_LOW: begin
                if (st.wakeArmed && wakeFall) begin
                    next_st.wake        = 1'b1;
                    next_st.pwr         = uiw_pkg::PWR_STARTUP;
                    next_st.cnt         = `UIW_CNT_W'(STARTUP_CYCLES - 1);
                    next_st.wakeIrqPend = wakeEnable & rx_irq_enable;
                end else if (!lowPowerRequest) begin
                    next_st.pwr = uiw_pkg::PWR_RUN;
                end
            end
            uiw_pkg::PWR_STARTUP: begin
                if (st.cnt == '0) begin
                    next_st.pwr = uiw_pkg::PWR_RUN;
                end else begin
                    next_st.cnt = st.cnt - `UIW_CNT_W'(1);
                end
            end
        endcase
        // Gate by UART and global enables and stack room
        next_st.irqN = ~passGates(eventAny, serial_irq_mask, global_irq_enable, stackFull);
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            st <= '{pwr: uiw_pkg::PWR_RUN, cnt: '0, irqN: 1'b1, rxPrev: 1'b1, default: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign irqReqN       = st.irqN;
    assign uartClkEnable = (st.pwr == uiw_pkg::PWR_RUN);
    assign rxDiscard     = (st.pwr == uiw_pkg::PWR_STARTUP);
    assign wakeUp        = st.wake;
    assign addrWord      = st.addr;

    // ============================================================
    // Checks
    // Interrupt pulse shape and gating
    chk_pulse_one: assert property (@(posedge clk) disable iff (!rstSync)
        !irqReqN |=> irqReqN)
        else $error("interrupt pulse longer than one cycle");

    chk_mask_gate: assert property (@(posedge clk) disable iff (!rstSync)
        !serial_irq_mask |=> irqReqN)
        else $error("interrupt while UART mask clear");

    chk_stack_full: assert property (@(posedge clk) disable iff (!rstSync)
        stackFull |=> irqReqN)
        else $error("interrupt while stack full");

    chk_global_gate: assert property (@(posedge clk) disable iff (!rstSync)
        !global_irq_enable |=> irqReqN)
        else $error("interrupt while global enable clear");

    // Source events
    chk_tx_event: assert property (@(posedge clk) disable iff (!rstSync)
        (st.pwr == uiw_pkg::PWR_RUN && txEmptyEvt && txEmptyIrqEnable && gatesOpen) |=> !irqReqN)
        else $error("enabled transmit empty event gave no interrupt");

    chk_rx_plain: assert property (@(posedge clk) disable iff (!rstSync)
        (st.pwr == uiw_pkg::PWR_RUN && rxAvailEvt && rx_irq_enable && !addr_detect_enable && gatesOpen)
        |=> !irqReqN)
        else $error("receive event without address detect gave no interrupt");

    chk_addr_qual: assert property (@(posedge clk) disable iff (!rstSync)
        (st.pwr == uiw_pkg::PWR_RUN && addr_detect_enable && rxAvailEvt && !highBit && !txEmptyEvt
         && !txIdleEvt && !ovrEvt && !st.wakeIrqPend) |=> irqReqN)
        else $error("address detect interrupt on data word");

    chk_addr_pulse: assert property (@(posedge clk) disable iff (!rstSync)
        addrWord |-> $past(addr_detect_enable))
        else $error("address word flagged with address detect off");

    // Low power and wake-up
    chk_clk_freeze: assert property (@(posedge clk) disable iff (!rstSync)
        (st.pwr == uiw_pkg::PWR_LOW) |-> !uartClkEnable)
        else $error("UART clock runs in low power");

    chk_low_quiet: assert property (@(posedge clk) disable iff (!rstSync)
        (st.pwr == uiw_pkg::PWR_LOW) |=> irqReqN)
        else $error("interrupt while in low power");

    chk_wake_arm: assert property (@(posedge clk) disable iff (!rstSync)
        wakeUp |-> $past(st.wakeArmed))
        else $error("wake without arming");

    chk_wake_pend: assert property (@(posedge clk) disable iff (!rstSync)
        wakeUp |-> (st.wakeIrqPend == $past(wakeEnable & rx_irq_enable)))
        else $error("wake interrupt pending does not follow enables");

    chk_startup_load: assert property (@(posedge clk) disable iff (!rstSync)
        wakeUp |-> (rxDiscard && st.cnt == `UIW_CNT_W'(STARTUP_CYCLES - 1)))
        else $error("start-up delay not loaded on wake");

    chk_startup_end: assert property (@(posedge clk) disable iff (!rstSync)
        (rxDiscard && st.cnt == '0) |=> (!rxDiscard && uartClkEnable))
        else $error("start-up delay does not end on time");

    chk_startup_quiet: assert property (@(posedge clk) disable iff (!rstSync)
        rxDiscard |=> irqReqN)
        else $error("interrupt during start-up");

    // Main scenarios
    cov_irq: cover property (@(posedge clk) disable iff (!rstSync) !irqReqN);
    cov_wake: cover property (@(posedge clk) disable iff (!rstSync) wakeUp);
    cov_addr: cover property (@(posedge clk) disable iff (!rstSync) addrWord);
    cov_wake_irq: cover property (@(posedge clk) disable iff (!rstSync)
        (st.pwr == uiw_pkg::PWR_RUN && st.wakeIrqPend && gatesOpen));
endmodule : uiw_irq_wake

/* testbench/uiw_far_side.sv */
// Far side: remote RX line and interrupt controller pulse counter
module uiw_far_side (
    // Clock and requests
    input  wire logic clk,
    input  wire logic fallReq,
    input  wire logic irqReqN,
    // Line and count
    output logic      rxPin,
    output int        irqCount
);
    timeunit 1ns;
    timeprecision 1ns;
    int lowLeft = 0;
    initial rxPin = 1'b1;
    initial irqCount = 0;
    // Start bit edge, then back to idle high
    always @(posedge clk) begin
        lowLeft <= fallReq ? 3 : (lowLeft > 0 ? lowLeft - 1 : 0);
        rxPin <= !(fallReq || lowLeft > 1);
        if (irqReqN === 1'b0) irqCount <= irqCount + 1;
    end
endmodule : uiw_far_side

/* testbench/uiw_irq_wake_test.sv */
// Bench of the UART interrupt merge and RX wake-up logic
module uiw_irq_wake_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SU = 4;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [3:0] flg = 4'h0;
    logic [8:0] word = 9'h000;
    logic [5:0] ctl = 6'h00;
    logic [4:0] gate = 5'h0F;
    logic       lpr = 1'b0;
    logic       fallReq = 1'b0;
    logic       rxPin, irqReqN, clkEn, wakeUp, rxDiscard, addrWord;
    int         irqCount, base;
    int         addrCount = 0;
    int         fail_count = 0;
    int         total_checks = 0;
    initial begin
        forever #25 clk = ~clk;
    end
    uiw_irq_wake #(.STARTUP_CYCLES(SU)) uiw_irq_wake_inst (.clk(clk), .rstn(rstn),
        .txRegEmptyFlag(flg[0]), .txIdleFlag(flg[1]), .rx_data_avail_flag(flg[2]), .rxOverrunFlag(flg[3]),
        .rxWord(word), .txEmptyIrqEnable(ctl[0]), .txIdleIrqEnable(ctl[1]), .rx_irq_enable(ctl[2]),
        .addr_detect_enable(ctl[3]), .wakeEnable(ctl[4]), .word_length_select(ctl[5]),
        .serial_unit_enable(gate[0]), .receiver_enable(gate[1]), .global_irq_enable(gate[2]),
        .serial_irq_mask(gate[3]), .stackFull(gate[4]), .lowPowerRequest(lpr), .rxPin(rxPin),
        .irqReqN(irqReqN), .uartClkEnable(clkEn), .wakeUp(wakeUp), .rxDiscard(rxDiscard), .addrWord(addrWord));
    uiw_far_side uiw_far_side_inst (.clk(clk), .fallReq(fallReq), .irqReqN(irqReqN), .rxPin(rxPin),
        .irqCount(irqCount));
    always @(posedge clk) begin
        if (addrWord === 1'b1) addrCount <= addrCount + 1;
    end
    // ====
    // Helpers
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic fire(input int idx, input logic [8:0] w, input int exp);
        @(posedge clk);
        base = irqCount;
        word <= w;
        flg[idx] <= 1'b1;
        repeat (4) @(posedge clk);
        flg[idx] <= 1'b0;
        repeat (3) @(posedge clk);
        check("irq pulses", exp, irqCount - base);
    endtask : fire
    task automatic wake(input logic gie, input int exp);
        int n = 0;
        @(posedge clk);
        ctl <= 6'h14;
        gate <= {2'b01, gie, 2'b11};
        @(posedge clk);
        lpr <= 1'b1;
        repeat (3) @(negedge clk);
        check("clock enable", 0, clkEn);
        base = irqCount;
        @(posedge clk) fallReq <= 1'b1;
        @(posedge clk) fallReq <= 1'b0;
        while (wakeUp !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n >= 10) begin
            fail_count++;
            give_verdict();
        end
        @(posedge clk) lpr <= 1'b0;
        @(negedge clk);
        check("rx discard", 1, rxDiscard);
        repeat (SU - 2) @(negedge clk);
        check("early irq", 0, irqCount - base);
        repeat (8) @(negedge clk);
        check("wake irq", exp, irqCount - base);
        check("clock enable", 1, clkEn);
        $display("wake test done");
    endtask : wake
    // ====
    // Sequence
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            ctl <= 6'h00;
            fire(i, 9'h000, 0);
            ctl <= 6'h03;
            fire(i, 9'h000, 1);
        end
        ctl <= 6'h04;
        fire(2, 9'h000, 1);
        fire(3, 9'h000, 1);
        ctl <= 6'h00;
        fire(3, 9'h000, 0);
        ctl <= 6'h0C;
        fire(2, 9'h07F, 0);
        fire(2, 9'h080, 1);
        ctl <= 6'h2C;
        fire(2, 9'h080, 0);
        fire(2, 9'h100, 1);
        check("address words", 2, addrCount);
        $display("event test done");
        ctl <= 6'h01;
        gate <= 5'h07;
        fire(0, 9'h000, 0);
        gate <= 5'h1F;
        fire(0, 9'h000, 0);
        $display("gate test done");
        wake(1'b1, 1);
        wake(1'b0, 0);
        give_verdict();
    end
endmodule : uiw_irq_wake_test
